// ---- verilog/sstx_defs.svh ----
// constants for the source-synchronous transmit output stage
// assumes one 100 MHz clock; one clk cycle is one quarter of a forwarded clock period
`ifndef SSTX_DEFS_SVH
`define SSTX_DEFS_SVH

`define SSTX_CLK_MHZ 100
`define SSTX_SDR_MAX_MHZ 300
// ticks per edge clock period and per forwarded-clock quarter (90 degrees)
`define SSTX_TICKS_PER_FAST_EDGE_CLOCK 4
`define SSTX_QUAD_TICKS 3'h1
`define SSTX_LAST_X1 3'h3
`define SSTX_LAST_X2 3'h7
`define SSTX_FWD_FIRST 1'b1
`define SSTX_FWD_SECOND 1'b0
`define SSTX_WORD_W 4
`define SSTX_FIFO_DEPTH 8
`define SSTX_DEL_W 3
`define SSTX_STATIC_DEL 3'h3
`define SSTX_DYN_DEL_RST 3'h0
`define SSTX_WORD_RST 4'h0
`define SSTX_STOP_NS 40
`define SSTX_STOP_CYC ((`SSTX_STOP_NS * `SSTX_CLK_MHZ + 999) / 1000)
`define SSTX_REL_NS 30
`define SSTX_REL_CYC ((`SSTX_REL_NS * `SSTX_CLK_MHZ + 999) / 1000)
`define SSTX_CNT_W 4

`endif

// ---- verilog/sstx_pkg.sv ----
// types shared by the transmit stage modules
// assumes sstx_defs.svh sits on the include path
`include "sstx_defs.svh"

package sstx_pkg;
	typedef enum logic [2:0] {
		SSTX_SDR,
		SSTX_DDR1_ALIGNED,
		SSTX_DDR1_CENTRED,
		SSTX_DDR2_ALIGNED,
		SSTX_DDR2_CENTRED
	} sstx_mode_t;

	typedef enum logic [1:0] {
		SSTX_DEL_BYPASS,
		SSTX_DEL_STATIC,
		SSTX_DEL_DYNAMIC
	} sstx_del_sel_t;

	typedef enum logic {
		SSTX_KIND_DEFAULT,
		SSTX_KIND_CUSTOM
	} sstx_del_kind_t;

	typedef enum logic [1:0] {
		SSTX_SY_STOP,
		SSTX_SY_RELEASE,
		SSTX_SY_RUN
	} sstx_sync_st_t;
endpackage

// ---- verilog/sstx_fifo.sv ----
// word FIFO between the core source and the serializer
// assumes one clock; storage is flip-flops indexed by pointer
module sstx_fifo #(
	parameter int W = 4,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import sstx_pkg::*;

	localparam int AW = $clog2(D);

	logic [W-1:0] mem_ff [D];
	logic [AW:0] wr_ff;
	logic [AW:0] rd_ff;
	wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
	wire empty = (wr_ff == rd_ff);
	wire do_wr = ce && in_valid && !full;
	wire do_rd = ce && out_ready && !empty;

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_ff[rd_ff[AW-1:0]];

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem_ff[wr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge srst) begin
		if (srst) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (do_wr) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (do_rd) begin
				rd_ff <= rd_ff + 1'b1;
			end
		end
	end
endmodule

// ---- verilog/sstx_sync.sv ----
// startup sequencer: holds the edge clock gate stopped, releases the
// serializer and divider resets, then opens the gate
// assumes restart is a one-cycle pulse from the top
`include "sstx_defs.svh"
module sstx_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic restart,
	output logic gate_stop,
	output logic ser_rst,
	output logic ready
);
	import sstx_pkg::*;

	sstx_sync_st_t st_ff;
	sstx_sync_st_t nxt_st;
	logic [`SSTX_CNT_W-1:0] cnt_ff;
	logic [`SSTX_CNT_W-1:0] nxt_cnt;

	localparam logic [`SSTX_CNT_W-1:0] STOP_LAST = `SSTX_CNT_W'(`SSTX_STOP_CYC - 1);
	localparam logic [`SSTX_CNT_W-1:0] REL_LAST = `SSTX_CNT_W'(`SSTX_REL_CYC - 1);

	// resets drop only while the gate is stopped, so no edge reaches a half-reset divider
	assign gate_stop = (st_ff != SSTX_SY_RUN);
	assign ser_rst = (st_ff == SSTX_SY_STOP);
	assign ready = (st_ff == SSTX_SY_RUN);

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff + 1'b1;
		unique case (st_ff)
			SSTX_SY_STOP: begin
				if (cnt_ff == STOP_LAST) begin
					nxt_st = SSTX_SY_RELEASE;
					nxt_cnt = '0;
				end
			end
			SSTX_SY_RELEASE: begin
				if (cnt_ff == REL_LAST) begin
					nxt_st = SSTX_SY_RUN;
					nxt_cnt = '0;
				end
			end
			SSTX_SY_RUN: begin
				nxt_cnt = '0;
			end
		endcase
		if (restart) begin
			nxt_st = SSTX_SY_STOP;
			nxt_cnt = '0;
		end
	end

	always_ff @(posedge clk or posedge srst) begin
		if (srst) begin
			st_ff <= SSTX_SY_STOP;
			cnt_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// ---- verilog/sstx_top.sv ----
// source-synchronous transmit output stage: sdr, ddr 1:1 and ddr 2:1,
// edge-aligned or centred forwarded clock, optional data delay and tri-state
// assumes clk is a tick clock four times the edge clock; pins are sampled per tick
`include "sstx_defs.svh"
module sstx_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire sstx_pkg::sstx_mode_t mode,
	input wire sstx_pkg::sstx_del_sel_t del_sel,
	input wire logic dyn_del_load,
	input wire logic [`SSTX_DEL_W-1:0] dyn_del_val,
	input wire logic outen_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [`SSTX_WORD_W-1:0] in_data,
	output logic data_o,
	output logic data_oe,
	output logic fclk_o,
	output logic fclk_oe,
	output logic sclk_o,
	output logic fast_edge_clock_o,
	output sstx_pkg::sstx_del_kind_t delay_kind_attr,
	output logic [`SSTX_DEL_W-1:0] del_tap_o,
	output logic tx_ready,
	output logic underrun,
	output logic rate_ok
);
	import sstx_pkg::*;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	function automatic logic is_x2(input sstx_mode_t m);
		return (m == SSTX_DDR2_ALIGNED) || (m == SSTX_DDR2_CENTRED);
	endfunction

	function automatic logic is_centred(input sstx_mode_t m);
		return (m == SSTX_DDR1_CENTRED) || (m == SSTX_DDR2_CENTRED);
	endfunction

	// sdr forwarded rate is one bit per edge clock period
	localparam int FWD_MHZ = `SSTX_CLK_MHZ / `SSTX_TICKS_PER_FAST_EDGE_CLOCK;
	assign rate_ok = (FWD_MHZ <= `SSTX_SDR_MAX_MHZ);

	sstx_mode_t mode_ff;
	wire mode_chg = (mode != mode_ff);
	wire gear_x2 = is_x2(mode_ff);
	wire centred = is_centred(mode_ff);
	wire sdr = (mode_ff == SSTX_SDR);

	// ------------------------------------------------------------
	// startup sequencing and clocks
	// ------------------------------------------------------------
	logic gate_stop;
	logic ser_rst;

	sstx_sync u_sync (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.restart(mode_chg),
		.gate_stop(gate_stop),
		.ser_rst(ser_rst),
		.ready(tx_ready)
	);

	logic [2:0] tick_ff;
	wire [2:0] tick_last = gear_x2 ? `SSTX_LAST_X2 : `SSTX_LAST_X1;
	wire word_end = (tick_ff == tick_last);
	// tick only advances while the gate is open: the gated fast edge clock
	wire [2:0] nxt_tick = ser_rst ? 3'h0 : gate_stop ? tick_ff : word_end ? 3'h0 : tick_ff + 3'h1;
	wire fast_edge_clock_lvl = !gate_stop && !tick_ff[1];
	// slow clock is the edge clock divided by two in 2:1 gearing
	wire sclk_lvl = gear_x2 ? (!gate_stop && !tick_ff[2]) : fast_edge_clock_lvl;

	// ------------------------------------------------------------
	// word capture and bit slot select
	// ------------------------------------------------------------
	logic fifo_valid;
	logic [`SSTX_WORD_W-1:0] fifo_data;
	wire load = tx_ready && word_end;

	sstx_fifo #(
		.W(`SSTX_WORD_W),
		.D(`SSTX_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_data),
		.out_valid(fifo_valid),
		.out_ready(load),
		.out_data(fifo_data)
	);

	// word register on the slow clock rising edge; empty FIFO sends zeros
	logic [`SSTX_WORD_W-1:0] word_ff;
	wire [`SSTX_WORD_W-1:0] nxt_word = fifo_valid ? fifo_data : `SSTX_WORD_RST;

	// sdr: one bit per word; ddr 1:1: two slots; ddr 2:1: four slots, lsb first
	wire [1:0] slot = sdr ? 2'h0 : gear_x2 ? tick_ff[2:1] : {1'b0, tick_ff[1]};
	wire bit_now = word_ff[slot];

	// ------------------------------------------------------------
	// forwarded clock
	// ------------------------------------------------------------
	// centred modes read the reference one quarter period late
	wire [2:0] fwd_tick = centred ? tick_ff - `SSTX_QUAD_TICKS : tick_ff;
	wire fwd_first_slot = !fwd_tick[1];
	// 1:1 ddr element with constant one then zero reproduces its clock
	wire fwd_src = gate_stop ? `SSTX_FWD_SECOND : fwd_first_slot ? `SSTX_FWD_FIRST : `SSTX_FWD_SECOND;

	// ------------------------------------------------------------
	// data delay
	// ------------------------------------------------------------
	logic [`SSTX_DEL_W-1:0] dyn_del_ff;
	logic [(1 << `SSTX_DEL_W)-1:0] dl_ff;
	// dynamic value overrides the configured default at run time
	wire [`SSTX_DEL_W-1:0] tap = (del_sel == SSTX_DEL_STATIC) ? `SSTX_STATIC_DEL :
		(del_sel == SSTX_DEL_DYNAMIC) ? dyn_del_ff : '0;
	assign delay_kind_attr = (del_sel == SSTX_DEL_BYPASS) ? SSTX_KIND_DEFAULT : SSTX_KIND_CUSTOM;
	assign del_tap_o = tap;

	// clock path gets the same one-tick register as data tap zero, keeping alignment
	logic fclk_ff;
	logic oen_ff;
	logic under_ff;
	logic sclk_ff;
	logic fast_edge_clock_ff;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge srst) begin
		if (srst) begin
			mode_ff <= SSTX_SDR;
			tick_ff <= 3'h0;
		end else if (ce) begin
			mode_ff <= mode;
			tick_ff <= nxt_tick;
		end
	end

	// output registers clear as soon as reset rises
	always_ff @(posedge clk or posedge srst) begin
		if (srst) begin
			word_ff <= `SSTX_WORD_RST;
			dl_ff <= '0;
			fclk_ff <= 1'b0;
			oen_ff <= 1'b0;
		end else if (ce) begin
			if (load) begin
				word_ff <= nxt_word;
			end
			dl_ff <= {dl_ff[(1 << `SSTX_DEL_W)-2:0], bit_now};
			fclk_ff <= fwd_src;
			oen_ff <= outen_n;
		end
	end

	always_ff @(posedge clk or posedge srst) begin
		if (srst) begin
			dyn_del_ff <= `SSTX_DYN_DEL_RST;
			under_ff <= 1'b0;
			sclk_ff <= 1'b0;
			fast_edge_clock_ff <= 1'b0;
		end else if (ce) begin
			if (dyn_del_load) begin
				dyn_del_ff <= dyn_del_val;
			end
			under_ff <= load && !fifo_valid;
			sclk_ff <= sclk_lvl;
			fast_edge_clock_ff <= fast_edge_clock_lvl;
		end
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	assign data_o = dl_ff[tap];
	// registered enable floats both pins together
	assign data_oe = !oen_ff;
	assign fclk_o = fclk_ff;
	assign fclk_oe = !oen_ff;
	assign sclk_o = sclk_ff;
	assign fast_edge_clock_o = fast_edge_clock_ff;
	assign underrun = under_ff;
endmodule

// ---- testbench/sstx_sva.sv ----
// pin-level assertions for the transmit stage, bound into sstx_top
// assumes the bench holds ce high; one tick per clk
`include "sstx_defs.svh"
module sstx_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire sstx_pkg::sstx_mode_t mode,
	input wire sstx_pkg::sstx_del_sel_t del_sel,
	input wire logic dyn_del_load,
	input wire logic [`SSTX_DEL_W-1:0] dyn_del_val,
	input wire logic outen_n,
	input wire logic data_o,
	input wire logic data_oe,
	input wire logic fclk_o,
	input wire logic fclk_oe,
	input wire sstx_pkg::sstx_del_kind_t delay_kind_attr,
	input wire logic [`SSTX_DEL_W-1:0] del_tap_o,
	input wire logic tx_ready,
	input wire logic underrun,
	input wire logic rate_ok,
	input wire logic sclk_o,
	input wire logic fast_edge_clock_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import sstx_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire bypass = del_sel == SSTX_DEL_BYPASS;
	wire centred = mode == SSTX_DDR1_CENTRED || mode == SSTX_DDR2_CENTRED;
	// edge relations only hold on the undelayed path
	wire run = tx_ready && bypass;
	wire x2 = mode == SSTX_DDR2_ALIGNED || mode == SSTX_DDR2_CENTRED;
	a_rst_clear: assert property (disable iff (1'h0) srst |-> !data_o && !fclk_o && data_oe && !tx_ready)
		else $error("outputs not cleared in reset");
	a_oe_reg: assert property (ce |=> data_oe == !$past(outen_n) && fclk_oe == data_oe)
		else $error("enable register wrong");
	a_kind_sel: assert property (delay_kind_attr == (bypass ? SSTX_KIND_DEFAULT : SSTX_KIND_CUSTOM))
		else $error("delay kind wrong");
	a_static_tap: assert property (del_sel == SSTX_DEL_STATIC |-> del_tap_o == `SSTX_STATIC_DEL)
		else $error("static tap wrong");
	a_dyn_load: assert property (ce && dyn_del_load ##1 !bypass && !del_sel[0] |-> del_tap_o == $past(dyn_del_val))
		else $error("dynamic tap not loaded");
	// a mode other than the reset one restarts the sequencer on the first edge, one tick more
	a_ready_time: assert property ($fell(srst) && mode == SSTX_SDR |-> !tx_ready [*7] ##1 tx_ready)
		else $error("startup length wrong");
	a_ready_ddr: assert property ($fell(srst) && mode != SSTX_SDR |-> !tx_ready [*8] ##1 tx_ready)
		else $error("ddr startup length wrong");
	a_fclk_shape: assert property (disable iff (srst || !tx_ready) $rose(fclk_o) |=> fclk_o ##1 !fclk_o [*2] ##1 fclk_o)
		else $error("forwarded clock shape wrong");
	a_centre_mid: assert property (centred && run && $changed(fclk_o) |-> $stable(data_o))
		else $error("centred edge on data change");
	a_align_edge: assert property (!centred && run && $past(run) && $changed(data_o) |-> $changed(fclk_o))
		else $error("aligned data change off clock edge");
	a_rate_ok: assert property (rate_ok)
		else $error("rate flag low");
	a_sclk_div: assert property (disable iff (srst || !tx_ready) x2 && $rose(sclk_o) |-> $rose(fast_edge_clock_o) ##4 ($rose(fast_edge_clock_o) && !sclk_o))
		else $error("slow clock not edge clock halved");
	a_sclk_same: assert property (!x2 |-> sclk_o == fast_edge_clock_o)
		else $error("slow clock differs from edge clock");
	c_ready: cover property ($rose(tx_ready));
	c_under: cover property (underrun);
	c_float: cover property (!data_oe);
endmodule

bind sstx_top sstx_chk i_chk (.clk, .srst, .ce, .mode, .del_sel, .dyn_del_load, .dyn_del_val, .outen_n,
	.data_o, .data_oe, .fclk_o, .fclk_oe, .delay_kind_attr, .del_tap_o, .tx_ready, .underrun, .rate_ok,
	.sclk_o, .fast_edge_clock_o);

// ---- testbench/sstx_rx_model.sv ----
// far-side receiver: samples the data pin at each forwarded clock edge
// assumes pins are seen once per tick; keeps the last 8 bits per edge kind
module sstx_rx_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic data_o,
	input wire logic fclk_o,
	input wire logic fclk_oe,
	output logic [7:0] rise_bits,
	output logic [7:0] fall_bits
);
	timeunit 1ns;
	timeprecision 1ns;
	logic fclk_last;
	always @(posedge clk) begin
		fclk_last <= fclk_o;
		// a pattern no stream yields, so a stale history never matches
		if (srst || !fclk_oe) begin
			rise_bits <= 8'h5a;
			fall_bits <= 8'h5a;
		end else if (fclk_o && !fclk_last) begin
			rise_bits <= {rise_bits[6:0], data_o};
		end else if (!fclk_o && fclk_last) begin
			fall_bits <= {fall_bits[6:0], data_o};
		end
	end
endmodule

// ---- testbench/sstx_top_tb.sv ----
// bench for sstx_top: streams words in every mode, then drain, tri-state, delay
// assumes design files, checker and receiver model compiled first
`include "sstx_defs.svh"
module sstx_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sstx_pkg::*;
	logic clk, srst, ce, dyn_del_load, outen_n, in_valid, in_ready, data_o, data_oe;
	logic fclk_o, fclk_oe, sclk_o, fast_edge_clock_o, tx_ready, underrun, rate_ok, saw_full, saw_under;
	sstx_mode_t mode;
	sstx_del_sel_t del_sel;
	sstx_del_kind_t delay_kind_attr;
	logic [`SSTX_DEL_W-1:0] dyn_del_val, del_tap_o;
	logic [3:0] in_data, w;
	logic [7:0] rise_bits, fall_bits;
	int num_errors = 0, checks = 0, cyc = 0;
	sstx_top i_dut (.clk, .srst, .ce, .mode, .del_sel, .dyn_del_load, .dyn_del_val, .outen_n, .in_valid,
		.in_ready, .in_data, .data_o, .data_oe, .fclk_o, .fclk_oe, .sclk_o, .fast_edge_clock_o, .delay_kind_attr,
		.del_tap_o, .tx_ready, .underrun, .rate_ok);
	sstx_rx_model i_rx (.clk, .srst, .data_o, .fclk_o, .fclk_oe, .rise_bits, .fall_bits);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		saw_full |= !in_ready;
		saw_under |= underrun;
		if (cyc == 3000) begin
			num_errors++;
			complete_run();
		end
	end
	// ----------
	// tasks
	// ----------
	task complete_run();
		if (num_errors == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task stream(input sstx_mode_t m, input logic [3:0] v);
		srst = 1;
		mode = m;
		#2;
		check("reset pins", {3'h0, data_o, fclk_o, tx_ready, underrun, data_oe}, 8'h01);
		tick(10);
		srst = 0;
		in_valid = 1;
		in_data = v;
		tick(80);
		in_valid = 0;
	endtask
	// ----------
	// sequence
	// ----------
	initial begin
		// low first, so the first stream gives the async clear a real rising edge
		srst = 0; ce = 1; mode = SSTX_SDR; del_sel = SSTX_DEL_BYPASS; dyn_del_load = 0;
		dyn_del_val = 0; outen_n = 0; in_valid = 0; in_data = 0; saw_full = 0; saw_under = 0;
		#1;
		for (int i = 0; i < 10; i++) begin
			w = i[0] ? 4'h5 : 4'ha;
			stream(sstx_mode_t'(i / 2), w);
			check("rise bits", rise_bits, {8{w[0]}});
			check("fall bits", fall_bits, {8{i < 2 ? w[0] : w[1]}});
		end
		check("fifo refused", {7'h0, saw_full}, 8'h01);
		saw_under = 0;
		tick(100);
		check("underrun seen", {7'h0, saw_under}, 8'h01);
		check("idle bits", rise_bits | fall_bits, 8'h00);
		outen_n = 1;
		tick(2);
		check("floated", {6'h0, data_oe, fclk_oe}, 8'h00);
		outen_n = 0;
		tick(2);
		check("driven", {6'h0, data_oe, fclk_oe}, 8'h03);
		check("tap bypass", {4'h0, delay_kind_attr, del_tap_o}, 8'h00);
		del_sel = SSTX_DEL_STATIC;
		tick(1);
		check("tap static", {4'h0, delay_kind_attr, del_tap_o}, 8'h0b);
		del_sel = SSTX_DEL_DYNAMIC;
		dyn_del_val = 5;
		dyn_del_load = 1;
		tick(1);
		dyn_del_load = 0;
		tick(1);
		check("tap dynamic", {4'h0, delay_kind_attr, del_tap_o}, 8'h0d);
		check("rate", {7'h0, rate_ok}, 8'h01);
		complete_run();
	end
endmodule
